// file: src/csf_regs.sv
// status, fault and battery-short config registers of the charger
`timescale 1ns/1ps
`default_nettype none
`include "csf_map.svh"
module csf_regs #(
  parameter int unsigned SEC_CYCLES = `CSF_SEC_CYCLES
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_supply_cycle,
  input  wire csf_pkg::csf_req_type i_req,
  input  wire csf_pkg::csf_sense_type i_sense,
  input  wire logic                 i_recharge_disable,
  input  wire logic [2:0]           i_charger_state,
  output logic [7:0]                o_rdata,
  output logic [2:0]                o_short_threshold_sel
);
  import csf_pkg::*;

  // two-stage synchronisers for comparator inputs
  csf_sense_type sense_meta;
  csf_sense_type sense;
  logic          supply_meta;
  logic          supply_sync;
  logic [7:0]    fault_flags;
  logic [7:0]    battery_short_config;
  logic [27:0]   short_cnt;
  logic [7:0]    short_secs;
  logic [7:0]    timeout_secs;
  logic          short_event;
  logic          recharge_needed_flag;
  logic [7:0]    charger_status_two;
  logic [7:0]    next_fault;
  logic [7:0]    fault_clear;
  logic [7:0]    fault_set;
  logic          wr_fault;
  logic          wr_cfg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sense_meta  <= '0;
      sense       <= '0;
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      sense_meta  <= i_sense;
      sense       <= sense_meta;
      supply_meta <= i_supply_cycle;
      supply_sync <= supply_meta;
    end
  end

  function automatic logic [7:0] timeout_of(input logic [2:0] code);
    case (code)
      3'h0:    timeout_of = `CSF_SHORT_TMO_0;
      3'h1:    timeout_of = `CSF_SHORT_TMO_1;
      3'h2:    timeout_of = `CSF_SHORT_TMO_2;
      3'h3:    timeout_of = `CSF_SHORT_TMO_3;
      3'h4:    timeout_of = `CSF_SHORT_TMO_4;
      3'h5:    timeout_of = `CSF_SHORT_TMO_5;
      3'h6:    timeout_of = `CSF_SHORT_TMO_6;
      default: timeout_of = `CSF_SHORT_TMO_7;
    endcase
  endfunction : timeout_of

  assign timeout_secs = timeout_of(battery_short_config[`CSF_CFG_TMO_LSB +: 3]); // [R09]
  assign o_short_threshold_sel = battery_short_config[`CSF_CFG_VTH_LSB +: 3]; // [R10]

  // recharge info live only at charge complete with recharge disabled
  assign recharge_needed_flag = i_recharge_disable &&
                                (i_charger_state == `CSF_CHG_COMPLETE) && // [R02] [R11]
                                sense.below_recharge; // [R03]
  assign charger_status_two = {sense.thermistor_zone, 1'b0, // [R01] [R13]
                               recharge_needed_flag, sense.battery_state}; // [R04]

  assign wr_fault = i_req.wr && (i_req.addr == `CSF_ADDR_FAULT);
  assign wr_cfg   = i_req.wr && (i_req.addr == `CSF_ADDR_SHORT_CFG);
  assign fault_clear = supply_sync ? 8'hff
                     : (wr_fault ? i_req.wdata : 8'h00); // [R08]
  assign fault_set = (8'(short_event) << `CSF_FLT_SHORT_BIT) | // [R05]
                     (8'(sense.overtemp_low_fault) << `CSF_FLT_OT_LOW_BIT) | // [R06]
                     (8'(sense.overtemp_high_fault) << `CSF_FLT_OT_HIGH_BIT); // [R07]
  // hardware set wins over a simultaneous clear
  assign next_fault = (fault_flags & ~fault_clear | fault_set) & `CSF_FLT_USED_MASK; // [R13]

  // short timer: seconds of continuous below-threshold
  assign short_event = sense.short_below && (short_secs >= timeout_secs); // [R12]

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      short_cnt  <= '0;
      short_secs <= 8'h00;
    end else if (!sense.short_below) begin
      short_cnt  <= '0;
      short_secs <= 8'h00;
    end else if (short_secs < timeout_secs) begin // [R12]
      if (short_cnt == 28'(SEC_CYCLES - 1)) begin
        short_cnt  <= '0;
        short_secs <= short_secs + 8'h01;
      end else begin
        short_cnt <= short_cnt + 28'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_flags          <= 8'h00;
      battery_short_config <= `CSF_CFG_RESET;
    end else begin
      fault_flags <= next_fault;
      if (wr_cfg) begin
        battery_short_config <= i_req.wdata & `CSF_CFG_USED_MASK; // [R13]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd && i_req.addr == `CSF_ADDR_STATUS_TWO) begin
      o_rdata <= charger_status_two;
    end else if (i_req.rd && i_req.addr == `CSF_ADDR_FAULT) begin
      o_rdata <= fault_flags;
    end else if (i_req.rd && i_req.addr == `CSF_ADDR_SHORT_CFG) begin
      o_rdata <= battery_short_config;
    end else if (i_req.rd) begin
      o_rdata <= 8'h00;
    end
  end

  property p_cfg_reset;
    @(posedge i_sys_clk) $rose(i_rst_n) |-> battery_short_config == `CSF_CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong"); // [R09]

  property p_sel_follow;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_cfg |=> o_short_threshold_sel == $past(i_req.wdata[2:0]);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("threshold select mismatch"); // [R10]

  property p_short_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      fault_flags[3] && !supply_sync && !(wr_fault && i_req.wdata[3]) |=> fault_flags[3];
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("short flag lost"); // [R05]

  property p_ot_low_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      sense.overtemp_low_fault |=> fault_flags[1];
  endproperty
  a_ot_low_set: assert property (p_ot_low_set) else $error("low overtemp not set"); // [R06]

  property p_ot_high_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      sense.overtemp_high_fault |=> fault_flags[0];
  endproperty
  a_ot_high_set: assert property (p_ot_high_set) else $error("high overtemp not set"); // [R07]

  property p_w1c;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_fault && i_req.wdata[0] && !supply_sync && !sense.overtemp_high_fault
      |=> !fault_flags[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [R08]

  property p_rch_gate;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_charger_state != `CSF_CHG_COMPLETE || !i_recharge_disable) |-> !charger_status_two[3];
  endproperty
  a_rch_gate: assert property (p_rch_gate) else $error("recharge flag active wrongly"); // [R02]

  property p_unused_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      fault_flags[7:4] == 4'h0 && !fault_flags[2] && battery_short_config[4:3] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero"); // [R13]

  property p_short_needs_time;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(fault_flags[3]) |-> $past(short_secs) >= $past(timeout_secs);
  endproperty
  a_short_needs_time: assert property (p_short_needs_time) else $error("short too early"); // [R12]

  property p_short_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      short_event |=> fault_flags[`CSF_FLT_SHORT_BIT];
  endproperty
  a_short_set: assert property (p_short_set) else $error("short flag not set"); // [R12]

  property p_ot_low_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      fault_flags[1] && !supply_sync && !(wr_fault && i_req.wdata[1]) |=> fault_flags[1];
  endproperty
  a_ot_low_hold: assert property (p_ot_low_hold) else $error("low overtemp flag lost"); // [R06]

  property p_supply_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      supply_sync && fault_set == 8'h00 |=> fault_flags == 8'h00;
  endproperty
  a_supply_clear: assert property (p_supply_clear) else $error("supply cycle kept a flag"); // [R08]

  property p_cfg_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_cfg |=> battery_short_config == ($past(i_req.wdata) & `CSF_CFG_USED_MASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [R09]

  property p_cfg_other_wr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr != `CSF_ADDR_SHORT_CFG |=> $stable(battery_short_config);
  endproperty
  a_cfg_other_wr: assert property (p_cfg_other_wr) else $error("config changed by other write"); // [R13]

  property p_rdata_fault;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_req.rd && i_req.addr == `CSF_ADDR_FAULT |=> o_rdata == $past(fault_flags);
  endproperty
  a_rdata_fault: assert property (p_rdata_fault) else $error("fault read data wrong"); // [R05]

  property p_unmapped_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_req.rd && i_req.addr != `CSF_ADDR_STATUS_TWO && i_req.addr != `CSF_ADDR_FAULT &&
      i_req.addr != `CSF_ADDR_SHORT_CFG |=> o_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // [R13]
endmodule : csf_regs
`default_nettype wire

// file: common/csf_map.svh
// register offsets, field positions, reset values and timing counts
// How it works
// R01 - thermistor zone is a 3-bit read-only code: off, cold, cool, warm, hot, normal.
// R02 - recharge-needed bit is live only when recharge disabled and charger state is 100.
// R03 - when live, recharge-needed reads 1 below recharge threshold, 0 above it.
// R04 - battery state is a 3-bit read-only code from monitor off to above weak.
// R05 - fault bit 3 sets on battery short and holds until cleared.
// R06 - fault bit 1 sets on lower overtemperature; resets to 0.
// R07 - fault bit 0 sets on upper overtemperature; resets to 0.
// R08 - writing 1 or a supply cycle clears a fault bit; writing 0 does nothing.
// R09 - config bits 7:5 pick short timeout 1 to 180 s; default code 100.
// R10 - config bits 2:0 pick short threshold 2.0 to 2.7 V; default code 100.
// R11 - charger state code 100 means charge complete.
// R12 - short flag sets when voltage stays below threshold for whole timeout.
// R13 - unused register bits read 0 and ignore writes.
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH
`define CSF_ADDR_STATUS_TWO   8'h0c
`define CSF_ADDR_FAULT        8'h0d
`define CSF_ADDR_SHORT_CFG    8'h10
`define CSF_FLT_SHORT_BIT     3
`define CSF_FLT_OT_LOW_BIT    1
`define CSF_FLT_OT_HIGH_BIT   0
`define CSF_FLT_USED_MASK     8'h0b
`define CSF_CFG_USED_MASK     8'he7
`define CSF_CFG_RESET         8'h84
`define CSF_CHG_COMPLETE      3'h4
`define CSF_CFG_TMO_LSB       5
`define CSF_CFG_VTH_LSB       0
`define CSF_SHORT_TMO_0       8'h01
`define CSF_SHORT_TMO_1       8'h02
`define CSF_SHORT_TMO_2       8'h04
`define CSF_SHORT_TMO_3       8'h0a
`define CSF_SHORT_TMO_4       8'h1e
`define CSF_SHORT_TMO_5       8'h3c
`define CSF_SHORT_TMO_6       8'h78
`define CSF_SHORT_TMO_7       8'hb4
`define CSF_CLK_HZ            250000000
`define CSF_SEC_CYCLES        (`CSF_CLK_HZ * 1)
`endif

// file: common/csf_pkg.sv
// types shared by the charger status and fault register bank
package csf_pkg;
  typedef struct packed {
    logic [2:0] thermistor_zone;
    logic       below_recharge;
    logic [2:0] battery_state;
    logic       short_below;
    logic       overtemp_low_fault;
    logic       overtemp_high_fault;
  } csf_sense_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csf_req_type;
endpackage : csf_pkg

// file: bench/csf_host.sv
// host model issuing register requests on the falling edge
`timescale 1ns/1ps
`default_nettype none
module csf_host (
  input  wire logic            i_sys_clk,
  output var csf_pkg::csf_req_type o_req
);
  import csf_pkg::*;
  initial o_req = '0;
  // released address and data lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk) o_req = '{1'b1, 1'b0, a, d};
    @(negedge i_sys_clk) o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge i_sys_clk) o_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_sys_clk) o_req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask : rd
endmodule : csf_host
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the charger status and fault registers
`timescale 1ns/1ps
`default_nettype none
`include "csf_map.svh"
module testbench;
  import csf_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          supply = 1'b0;
  logic          dis = 1'b0;
  logic [2:0]    state = 3'h0;
  csf_sense_type sense = '0;
  csf_req_type   req;
  logic [7:0]    rdata;
  logic [2:0]    thresh_sel;
  logic [7:0]    v;
  int            err_count = 0;
  int            compares = 0;
  logic [2:0]    zones [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  initial forever #2 clk = ~clk;
  csf_host host (.i_sys_clk(clk), .o_req(req));
  csf_regs #(.SEC_CYCLES(4)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_supply_cycle(supply),
    .i_req(req), .i_sense(sense), .i_recharge_disable(dis), .i_charger_state(state),
    .o_rdata(rdata), .o_short_threshold_sel(thresh_sel));
  function automatic logic [7:0] exp_status(csf_sense_type s, logic d, logic [2:0] c);
    return {s.thermistor_zone, 1'b0, d & (c == `CSF_CHG_COMPLETE) & s.below_recharge,
            s.battery_state};
  endfunction : exp_status
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic chk_sel(input logic [2:0] e);
    compares++;
    if (thresh_sel !== e) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, e, thresh_sel);
    end
  endtask : chk_sel
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a);
    chk(e, rdata);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #40000;
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hcc707f9c));
    idle(20);
    rst_n = 1'b1;
    rchk(`CSF_ADDR_SHORT_CFG, `CSF_CFG_RESET);
    chk_sel(3'h4);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      sense = '{zones[$urandom % 6], 1'($urandom), 3'($urandom % 5), 1'b0, 1'b0, 1'b0};
      dis = (i < 4) ? 1'b1 : 1'($urandom);
      state = (i < 4) ? 3'h4 : 3'($urandom);
      idle(4);
      rchk(`CSF_ADDR_STATUS_TWO, exp_status(sense, dis, state));
    end
    host.wr(`CSF_ADDR_STATUS_TWO, 8'hff);
    rchk(`CSF_ADDR_STATUS_TWO, exp_status(sense, dis, state));
    rchk(8'h55, 8'h00);
    $display("test status done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      host.wr(`CSF_ADDR_SHORT_CFG, v);
      rchk(`CSF_ADDR_SHORT_CFG, v & `CSF_CFG_USED_MASK);
      chk_sel(v[2:0]);
    end
    $display("test config done");
    sense.overtemp_low_fault = 1'b1;
    sense.overtemp_high_fault = 1'b1;
    idle(4);
    sense.overtemp_low_fault = 1'b0;
    sense.overtemp_high_fault = 1'b0;
    idle(4);
    rchk(`CSF_ADDR_FAULT, 8'h03);
    host.wr(`CSF_ADDR_FAULT, 8'h00);
    rchk(`CSF_ADDR_FAULT, 8'h03);
    host.wr(`CSF_ADDR_FAULT, 8'hf6);
    rchk(`CSF_ADDR_FAULT, 8'h01);
    host.wr(`CSF_ADDR_FAULT, 8'h01);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    $display("test overtemp done");
    // timeout code 001 is two seconds, eight cycles here
    host.wr(`CSF_ADDR_SHORT_CFG, 8'h20);
    sense.short_below = 1'b1;
    idle(5);
    sense.short_below = 1'b0;
    idle(4);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    sense.short_below = 1'b1;
    idle(14);
    sense.short_below = 1'b0;
    idle(4);
    rchk(`CSF_ADDR_FAULT, 8'h08);
    host.wr(`CSF_ADDR_FAULT, 8'h08);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    $display("test short done");
    sense.overtemp_high_fault = 1'b1;
    idle(4);
    sense.overtemp_high_fault = 1'b0;
    idle(4);
    rchk(`CSF_ADDR_FAULT, 8'h01);
    supply = 1'b1;
    idle(4);
    supply = 1'b0;
    idle(4);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    $display("test supply done");
    // reset in mid-run with a flag set and a non-default config
    sense.overtemp_high_fault = 1'b1;
    idle(4);
    sense.overtemp_high_fault = 1'b0;
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    rchk(`CSF_ADDR_SHORT_CFG, `CSF_CFG_RESET);
    chk_sel(3'h4);
    rchk(`CSF_ADDR_FAULT, 8'h00);
    $display("test mid reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
